//--- hw/dual_adc_sync_ctrl.sv
// Control logic for two linked converter units: slaving, start alignment, self test.
// Assumes all inputs come from register logic on the same 20 MHz clock.
`timescale 1ns/10ps
`default_nettype none
// Function
// R1: Selector 0x1 routes full-scale voltage to the check channel.
// R2: Selector 0x2 routes zero-scale voltage to the check channel.
// R3: Selector 0x3 routes the one-volt internal reference to the check channel.
// R4: Software alternates one fixed external input with each test source conversion.
// R5: Software passes self test if inputs agree and test results all differ.
// R6: Unit 1 mode sync bit set makes both units convert simultaneously.
// R7: Software programs equal channel counts on both units before linking them.
// R8: While linked, unit 0 mode applies to both; sync bit lives only in unit 1.
// R9: While linked, unit 0 control, interval, interrupt-mode and trigger govern both.
// R10: Each unit keeps its enables, limits, status, clear, test select and results.
// R11: Writing one to a clear bit drops its limit status within one clock; the code keeps the bit set if a new match arrives in that cycle.
// R12: While linked, both units start on the same edge from unit 0's start.
module dual_adc_sync_ctrl (
  // Clock and reset
  input  wire logic                               i_clk,
  input  wire logic                               i_resetn,
  // Shared-style settings, one copy per unit
  input  wire logic [adc_sync_pkg::MODE_W-1:0]    i_mode      [adc_sync_pkg::NUM_UNITS],
  input  wire logic [adc_sync_pkg::CTRL_W-1:0]    i_ctrl      [adc_sync_pkg::NUM_UNITS],
  input  wire logic [adc_sync_pkg::STM_W-1:0]     i_interval  [adc_sync_pkg::NUM_UNITS],
  input  wire logic [adc_sync_pkg::IMOD_W-1:0]    i_int_mode  [adc_sync_pkg::NUM_UNITS],
  input  wire logic [adc_sync_pkg::TRG_W-1:0]     i_trigger   [adc_sync_pkg::NUM_UNITS],
  input  wire logic                               i_start     [adc_sync_pkg::NUM_UNITS],
  // Per-unit private settings
  input  wire logic [adc_sync_pkg::NUM_CH-1:0]    i_chan_en   [adc_sync_pkg::NUM_UNITS],
  input  wire logic [adc_sync_pkg::NUM_CH-1:0]    i_limit_mode[adc_sync_pkg::NUM_UNITS],
  input  wire logic [adc_sync_pkg::RES_W-1:0]     i_upper     [adc_sync_pkg::NUM_UNITS],
  input  wire logic [adc_sync_pkg::RES_W-1:0]     i_lower     [adc_sync_pkg::NUM_UNITS],
  input  wire logic [adc_sync_pkg::NUM_CH-1:0]    i_limit_clr [adc_sync_pkg::NUM_UNITS],
  input  wire logic [adc_sync_pkg::TSEL_W-1:0]    i_test_sel  [adc_sync_pkg::NUM_UNITS],
  // Conversion results from the analog cores
  input  wire logic                               i_conv_valid[adc_sync_pkg::NUM_UNITS],
  input  wire logic [adc_sync_pkg::CHAN_W-1:0]    i_conv_chan [adc_sync_pkg::NUM_UNITS],
  input  wire logic [adc_sync_pkg::RES_W-1:0]     i_conv_data [adc_sync_pkg::NUM_UNITS],
  // Effective settings towards the analog cores
  output logic [adc_sync_pkg::MODE_W-1:0]         o_mode      [adc_sync_pkg::NUM_UNITS],
  output logic [adc_sync_pkg::CTRL_W-1:0]         o_ctrl      [adc_sync_pkg::NUM_UNITS],
  output logic [adc_sync_pkg::STM_W-1:0]          o_interval  [adc_sync_pkg::NUM_UNITS],
  output logic [adc_sync_pkg::IMOD_W-1:0]         o_int_mode  [adc_sync_pkg::NUM_UNITS],
  output logic [adc_sync_pkg::TRG_W-1:0]          o_trigger   [adc_sync_pkg::NUM_UNITS],
  output logic [adc_sync_pkg::NUM_CH-1:0]         o_chan_en   [adc_sync_pkg::NUM_UNITS],
  output logic                                    o_start     [adc_sync_pkg::NUM_UNITS],
  output logic                                    o_sync,
  // Per-unit state
  output adc_sync_pkg::check_src_e                o_check_src [adc_sync_pkg::NUM_UNITS],
  output logic [adc_sync_pkg::NUM_CH-1:0]         o_limit_status[adc_sync_pkg::NUM_UNITS],
  output logic [adc_sync_pkg::RES_W-1:0]          o_last_result[adc_sync_pkg::NUM_UNITS],
  output logic [adc_sync_pkg::RES_W-1:0]          o_result    [adc_sync_pkg::NUM_UNITS]
                                                              [adc_sync_pkg::NUM_CH]
);
  import adc_sync_pkg::*;

  // ****************************************************************
  // Linking
  // ****************************************************************
  logic sync_req;
  assign sync_req = i_mode[1][SYNC_BIT];

  // The sync bit of unit 0 is ignored so only unit 1 can link the pair.
  function automatic logic [MODE_W-1:0] strip_sync(input logic [MODE_W-1:0] m);
    logic [MODE_W-1:0] r;
    r = m;
    r[SYNC_BIT] = 1'b0;
    return r;
  endfunction : strip_sync

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sync <= 1'b0;
    end else begin
      o_sync <= sync_req; // R6
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int k = 0; k < NUM_UNITS; k++) begin
        o_mode[k]     <= MODE_RESET;
        o_ctrl[k]     <= CTRL_RESET;
        o_interval[k] <= STM_RESET;
        o_int_mode[k] <= IMOD_RESET;
        o_trigger[k]  <= TRG_RESET;
      end
    end else begin
      o_mode[0]     <= strip_sync(i_mode[0]); // R8
      o_ctrl[0]     <= i_ctrl[0];
      o_interval[0] <= i_interval[0];
      o_int_mode[0] <= i_int_mode[0];
      o_trigger[0]  <= i_trigger[0];
      if (sync_req) begin
        o_mode[1]     <= strip_sync(i_mode[0]) | (MODE_W'(1) << SYNC_BIT); // R8
        o_ctrl[1]     <= i_ctrl[0]; // R9
        o_interval[1] <= i_interval[0]; // R9
        o_int_mode[1] <= i_int_mode[0]; // R9
        o_trigger[1]  <= i_trigger[0]; // R9
      end else begin
        o_mode[1]     <= i_mode[1];
        o_ctrl[1]     <= i_ctrl[1];
        o_interval[1] <= i_interval[1];
        o_int_mode[1] <= i_int_mode[1];
        o_trigger[1]  <= i_trigger[1];
      end
    end
  end

  // Unit 1's own start is dropped while linked, so a stray trigger cannot skew the pair.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_start[0] <= 1'b0;
      o_start[1] <= 1'b0;
    end else begin
      o_start[0] <= i_start[0];
      o_start[1] <= sync_req ? i_start[0] : i_start[1]; // R12
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int k = 0; k < NUM_UNITS; k++) begin
        o_chan_en[k] <= '0;
      end
    end else begin
      for (int k = 0; k < NUM_UNITS; k++) begin
        o_chan_en[k] <= i_chan_en[k]; // R10
      end
    end
  end

  // ****************************************************************
  // Per-unit state
  // ****************************************************************
  for (genvar g = 0; g < NUM_UNITS; g++) begin : g_unit
    unit_if uif ();
    assign uif.conv_valid = i_conv_valid[g];
    assign uif.conv_chan  = i_conv_chan[g];
    assign uif.conv_data  = i_conv_data[g];
    assign uif.limit_mode = i_limit_mode[g];
    assign uif.upper      = i_upper[g];
    assign uif.lower      = i_lower[g];
    assign uif.clear      = i_limit_clr[g];
    assign uif.test_sel   = i_test_sel[g];
    assign o_limit_status[g] = uif.status;
    assign o_result[g]       = uif.results;
    assign o_last_result[g]  = uif.last_result;
    assign o_check_src[g]    = uif.check_src;

    adc_unit_core u_core (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .u        (uif.core)
    );
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_sync_follow: assert property (@(posedge i_clk) disable iff (!i_resetn) // R6
    sync_req |=> o_sync && o_mode[1][SYNC_BIT])
    else $error("link request not reflected");
  a_mode_slaved: assert property (@(posedge i_clk) disable iff (!i_resetn) // R8
    sync_req |=> o_mode[1] == ($past(strip_sync(i_mode[0])) | (MODE_W'(1) << SYNC_BIT)))
    else $error("unit 1 mode not taken from unit 0");
  a_unit0_no_sync: assert property (@(posedge i_clk) disable iff (!i_resetn) // R8
    i_mode[0][SYNC_BIT] && !sync_req |=> !o_sync && !o_mode[0][SYNC_BIT])
    else $error("unit 0 sync bit had effect");
  a_ctrl_slaved: assert property (@(posedge i_clk) disable iff (!i_resetn) // R9
    sync_req |=> o_ctrl[1] == $past(i_ctrl[0]) && o_trigger[1] == $past(i_trigger[0])
             && o_interval[1] == $past(i_interval[0])
             && o_int_mode[1] == $past(i_int_mode[0]))
    else $error("unit 1 control copy not slaved");
  a_start_aligned: assert property (@(posedge i_clk) disable iff (!i_resetn) // R12
    sync_req ##1 o_sync |-> o_start[1] == o_start[0])
    else $error("linked starts not on the same edge");
  a_enables_own: assert property (@(posedge i_clk) disable iff (!i_resetn) // R10
    1'b1 |=> o_chan_en[1] == $past(i_chan_en[1]))
    else $error("unit 1 enables not kept");

  // The leading reset term drops the attempt at the releasing edge, where the flops still
  // see reset, so these checks hold whatever the inputs carry while reset is applied.
  a_enables_unit0: assert property (@(posedge i_clk) disable iff (!i_resetn) // R10
    i_resetn |=> o_chan_en[0] == $past(i_chan_en[0]))
    else $error("unit 0 enables not kept");
  a_sync_drop: assert property (@(posedge i_clk) disable iff (!i_resetn) // R6
    i_resetn && !sync_req |=> !o_sync && !o_mode[1][SYNC_BIT])
    else $error("link kept after request dropped");
  a_unit0_mode_own: assert property (@(posedge i_clk) disable iff (!i_resetn) // R8
    i_resetn |=> o_mode[0] == $past(strip_sync(i_mode[0])))
    else $error("unit 0 mode not its own");
  a_unit0_ctrl_own: assert property (@(posedge i_clk) disable iff (!i_resetn) // R9
    i_resetn |=> o_ctrl[0] == $past(i_ctrl[0]) && o_trigger[0] == $past(i_trigger[0])
             && o_interval[0] == $past(i_interval[0])
             && o_int_mode[0] == $past(i_int_mode[0]))
    else $error("unit 0 control copy not its own");
  a_unlinked_mode: assert property (@(posedge i_clk) disable iff (!i_resetn) // R6
    i_resetn && !sync_req |=> o_mode[1] == $past(i_mode[1]))
    else $error("unlinked unit 1 mode not its own");
  a_unlinked_ctrl: assert property (@(posedge i_clk) disable iff (!i_resetn) // R6
    i_resetn && !sync_req |=> o_ctrl[1] == $past(i_ctrl[1])
             && o_trigger[1] == $past(i_trigger[1])
             && o_interval[1] == $past(i_interval[1]))
    else $error("unlinked unit 1 control copy not its own");
  a_start_unit0: assert property (@(posedge i_clk) disable iff (!i_resetn) // R12
    i_resetn |=> o_start[0] == $past(i_start[0]))
    else $error("unit 0 start not passed on");
  a_start_slaved: assert property (@(posedge i_clk) disable iff (!i_resetn) // R12
    i_resetn && sync_req |=> o_start[1] == $past(i_start[0]))
    else $error("linked unit 1 start not taken from unit 0");
  a_start_unlinked: assert property (@(posedge i_clk) disable iff (!i_resetn) // R6
    i_resetn && !sync_req |=> o_start[1] == $past(i_start[1]))
    else $error("unlinked unit 1 start not its own");

  c_linked_start: cover property (@(posedge i_clk) disable iff (!i_resetn)
    o_sync && o_start[0] && o_start[1]);
  c_unlinked_start: cover property (@(posedge i_clk) disable iff (!i_resetn)
    !o_sync && o_start[1] && !o_start[0]);
  c_link_toggle: cover property (@(posedge i_clk) disable iff (!i_resetn)
    !sync_req ##1 sync_req ##3 !sync_req);
endmodule : dual_adc_sync_ctrl
`default_nettype wire

//--- hw/adc_sync_pkg.sv
// Constants, types and decode helpers for the dual converter control block.
// Assumes both converter units and all control logic share one clock.
package adc_sync_pkg;

  localparam int NUM_UNITS = 2;
  localparam int NUM_CH    = 12;
  localparam int RES_W     = 12;
  localparam int CHAN_W    = 5;
  localparam int MODE_W    = 16;
  localparam int SYNC_BIT  = 15;
  localparam int CTRL_W    = 8;
  localparam int STM_W     = 8;
  localparam int IMOD_W    = 2;
  localparam int TRG_W     = 8;
  localparam int TSEL_W    = 2;

  localparam logic [TSEL_W-1:0] TSEL_FULL    = 2'h1;
  localparam logic [TSEL_W-1:0] TSEL_ZERO    = 2'h2;
  localparam logic [TSEL_W-1:0] TSEL_REF     = 2'h3;
  localparam logic [CHAN_W-1:0] CHECK_CHAN   = 5'h11;
  localparam logic [RES_W-1:0]  RESULT_RESET = 12'h000;
  localparam logic [NUM_CH-1:0] STATUS_RESET = 12'h000;
  localparam logic [MODE_W-1:0] MODE_RESET   = 16'h0000;
  localparam logic [CTRL_W-1:0] CTRL_RESET   = 8'h00;
  localparam logic [STM_W-1:0]  STM_RESET    = 8'h00;
  localparam logic [IMOD_W-1:0] IMOD_RESET   = 2'h0;
  localparam logic [TRG_W-1:0]  TRG_RESET    = 8'h00;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_FULL,
    SRC_ZERO,
    SRC_REF
  } check_src_e;

  // Maps the self-test selector onto the check channel source.
  function automatic check_src_e decode_test_src(input logic [TSEL_W-1:0] sel);
    check_src_e src;
    src = SRC_NONE;
    if (sel == TSEL_FULL) begin
      src = SRC_FULL;
    end else if (sel == TSEL_ZERO) begin
      src = SRC_ZERO;
    end else if (sel == TSEL_REF) begin
      src = SRC_REF;
    end
    return src;
  endfunction : decode_test_src

endpackage : adc_sync_pkg

//--- hw/unit_if.sv
// Per-unit bundle between the control top and one unit's private state.
// Assumes the top drives the settings and conversion strobe on the shared clock.
`timescale 1ns/10ps
`default_nettype none
interface unit_if;
  import adc_sync_pkg::*;
  logic                    conv_valid;
  logic [CHAN_W-1:0]       conv_chan;
  logic [RES_W-1:0]        conv_data;
  logic [NUM_CH-1:0]       limit_mode;
  logic [RES_W-1:0]        upper;
  logic [RES_W-1:0]        lower;
  logic [NUM_CH-1:0]       clear;
  logic [TSEL_W-1:0]       test_sel;
  logic [NUM_CH-1:0]       status;
  logic [RES_W-1:0]        results [NUM_CH];
  logic [RES_W-1:0]        last_result;
  check_src_e              check_src;

  modport top  (output conv_valid, conv_chan, conv_data, limit_mode, upper, lower, clear,
                test_sel, input status, results, last_result, check_src);
  modport core (input conv_valid, conv_chan, conv_data, limit_mode, upper, lower, clear,
                test_sel, output status, results, last_result, check_src);
endinterface : unit_if
`default_nettype wire

//--- hw/adc_unit_core.sv
// One converter unit's private state: results, limit status, test source.
// Assumes conversion strobes arrive from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module adc_unit_core (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Unit bundle
  unit_if.core      u
);
  import adc_sync_pkg::*;

  // ****************************************************************
  // Limit status and results
  // ****************************************************************
  logic [NUM_CH-1:0] set_vec;
  logic              in_range;
  logic              chan_ok;

  assign chan_ok  = u.conv_valid && (u.conv_chan < CHAN_W'(NUM_CH));
  assign in_range = (u.conv_data >= u.lower) && (u.conv_data <= u.upper);

  always_comb begin
    set_vec = '0;
    if (chan_ok && in_range && u.limit_mode[u.conv_chan[3:0]]) begin
      set_vec[u.conv_chan[3:0]] = 1'b1;
    end
  end

  // A new match in the cycle of its clear keeps the bit set.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      u.status <= STATUS_RESET;
    end else begin
      u.status <= (u.status & ~u.clear) | set_vec; // R10 R11
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        u.results[i] <= RESULT_RESET;
      end
      u.last_result <= RESULT_RESET;
    end else if (u.conv_valid) begin
      u.last_result <= u.conv_data;
      if (chan_ok) begin
        u.results[u.conv_chan[3:0]] <= u.conv_data; // R10
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      u.check_src <= SRC_NONE;
    end else begin
      u.check_src <= decode_test_src(u.test_sel); // R1 R2 R3 R10
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_full_scale_src: assert property (@(posedge i_clk) disable iff (!i_resetn) // R1
    u.test_sel == TSEL_FULL |=> u.check_src == SRC_FULL)
    else $error("full scale selector not routed");
  a_zero_scale_src: assert property (@(posedge i_clk) disable iff (!i_resetn) // R2
    u.test_sel == TSEL_ZERO |=> u.check_src == SRC_ZERO)
    else $error("zero scale selector not routed");
  a_ref_volt_src: assert property (@(posedge i_clk) disable iff (!i_resetn) // R3
    u.test_sel == TSEL_REF |=> u.check_src == SRC_REF)
    else $error("reference selector not routed");
  a_limit_clear_fast: assert property (@(posedge i_clk) disable iff (!i_resetn) // R11
    (u.clear != '0) && ((u.clear & set_vec) == '0) |=> (u.status & $past(u.clear)) == '0)
    else $error("limit status not cleared within one cycle");
  a_limit_set_wins: assert property (@(posedge i_clk) disable iff (!i_resetn) // R10
    set_vec != '0 |=> (u.status & $past(set_vec)) == $past(set_vec))
    else $error("limit match lost");
  a_result_store: assert property (@(posedge i_clk) disable iff (!i_resetn) // R10
    chan_ok |=> u.results[$past(u.conv_chan[3:0])] == $past(u.conv_data))
    else $error("result not stored in its channel slot");

  c_clear_and_set: cover property (@(posedge i_clk) disable iff (!i_resetn)
    (u.clear & set_vec) != '0);
  c_check_conv: cover property (@(posedge i_clk) disable iff (!i_resetn)
    u.conv_valid && u.conv_chan == CHECK_CHAN && u.check_src == SRC_FULL);
endmodule : adc_unit_core
`default_nettype wire

//--- tb/dual_adc_sync_and_self_test_tb_top.sv
// Self-checking bench for the dual converter control block with a cycle model.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module dual_adc_sync_and_self_test_tb_top;
  import adc_sync_pkg::*;
  // ********************************
  // Stimulus, outputs and model
  // ********************************
  logic              i_clk;
  logic              i_resetn;
  logic [MODE_W-1:0] md [NUM_UNITS];
  logic [CTRL_W-1:0] ct [NUM_UNITS];
  logic [STM_W-1:0]  iv [NUM_UNITS];
  logic [IMOD_W-1:0] im [NUM_UNITS];
  logic [TRG_W-1:0]  tg [NUM_UNITS];
  logic              st [NUM_UNITS];
  logic              cv [NUM_UNITS];
  logic [NUM_CH-1:0] en [NUM_UNITS], lm [NUM_UNITS], cl [NUM_UNITS];
  logic [NUM_CH-1:0] o_en [NUM_UNITS], o_ls [NUM_UNITS], e_en [NUM_UNITS], e_ls [NUM_UNITS];
  logic [RES_W-1:0]  up [NUM_UNITS], lo [NUM_UNITS], dt [NUM_UNITS];
  logic [TSEL_W-1:0] ts [NUM_UNITS];
  logic [CHAN_W-1:0] ch [NUM_UNITS];
  logic [MODE_W-1:0] o_md [NUM_UNITS], e_md [NUM_UNITS];
  logic [CTRL_W-1:0] o_ct [NUM_UNITS], e_ct [NUM_UNITS];
  logic [STM_W-1:0]  o_iv [NUM_UNITS], e_iv [NUM_UNITS];
  logic [IMOD_W-1:0] o_im [NUM_UNITS], e_im [NUM_UNITS];
  logic [TRG_W-1:0]  o_tg [NUM_UNITS], e_tg [NUM_UNITS];
  logic              o_st [NUM_UNITS], e_st [NUM_UNITS];
  logic              o_sy, e_sy;
  check_src_e        o_sr [NUM_UNITS], e_sr [NUM_UNITS];
  logic [RES_W-1:0]  o_la [NUM_UNITS], e_la [NUM_UNITS];
  logic [RES_W-1:0]  o_rs [NUM_UNITS][NUM_CH], e_rs [NUM_UNITS][NUM_CH];
  check_src_e        src_map [4] = '{SRC_NONE, SRC_FULL, SRC_ZERO, SRC_REF};
  int                mismatches, samples_checked, cycles;
  int                res_q [$];
  logic              st_ok;

  dual_adc_sync_ctrl uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_mode(md), .i_ctrl(ct),
    .i_interval(iv), .i_int_mode(im), .i_trigger(tg), .i_start(st), .i_chan_en(en),
    .i_limit_mode(lm), .i_upper(up), .i_lower(lo), .i_limit_clr(cl), .i_test_sel(ts),
    .i_conv_valid(cv), .i_conv_chan(ch), .i_conv_data(dt), .o_mode(o_md), .o_ctrl(o_ct),
    .o_interval(o_iv), .o_int_mode(o_im), .o_trigger(o_tg), .o_chan_en(o_en),
    .o_start(o_st), .o_sync(o_sy), .o_check_src(o_sr), .o_limit_status(o_ls),
    .o_last_result(o_la), .o_result(o_rs));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // ********************************
  // Cycle model: unit 0 governs unit 1 while linked
  // ********************************
  always @(posedge i_clk or negedge i_resetn) begin
    int v;
    logic lk;
    logic [NUM_CH-1:0] hit;
    lk = md[1][SYNC_BIT];
    e_sy = i_resetn & lk;
    for (int u = 0; u < NUM_UNITS; u++) begin
      v = (lk && u == 1) ? 0 : u;
      e_md[u] = (md[v] & 16'h7FFF) | ((lk && u == 1) ? 16'h8000 : 16'h0000);
      e_ct[u] = ct[v];
      e_iv[u] = iv[v];
      e_im[u] = im[v];
      e_tg[u] = tg[v];
      e_st[u] = st[v];
      e_en[u] = en[u];
      e_sr[u] = src_map[ts[u]];
      hit = '0;
      if (cv[u] && ch[u] < NUM_CH && lm[u][ch[u]] && dt[u] >= lo[u] && dt[u] <= up[u]) begin
        hit[ch[u]] = 1'b1;
      end
      e_ls[u] = (e_ls[u] & ~cl[u]) | hit;
      if (cv[u]) begin
        e_la[u] = dt[u];
        if (ch[u] < NUM_CH) begin
          e_rs[u][ch[u]] = dt[u];
        end
      end
      if (!i_resetn) begin
        {e_md[u], e_ct[u], e_iv[u], e_im[u], e_tg[u], e_st[u], e_en[u], e_ls[u], e_la[u]} = '0;
        e_sr[u] = SRC_NONE;
        e_rs[u] = '{default: '0};
      end
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (e !== g) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h at %0t", nm, e, g, $time);
    end
  endtask : chk

  always @(negedge i_clk) begin
    chk("sync", 16'(e_sy), 16'(o_sy));
    for (int u = 0; u < NUM_UNITS; u++) begin
      chk("mode", e_md[u], o_md[u]);
      chk("ctrl", 16'({e_ct[u], e_iv[u]}), 16'({o_ct[u], o_iv[u]}));
      chk("imod_trig", 16'({e_im[u], e_tg[u]}), 16'({o_im[u], o_tg[u]}));
      chk("start", 16'(e_st[u]), 16'(o_st[u]));
      chk("chan_en", 16'(e_en[u]), 16'(o_en[u]));
      chk("check_src", 16'(e_sr[u]), 16'(o_sr[u]));
      chk("limit_status", 16'(e_ls[u]), 16'(o_ls[u]));
      chk("last_result", 16'(e_la[u]), 16'(o_la[u]));
      for (int c = 0; c < NUM_CH; c++) chk("result", 16'(e_rs[u][c]), 16'(o_rs[u][c]));
    end
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      test_done();
    end
  end

  // ********************************
  // Drivers
  // ********************************
  // Channel 31 stands for an idle cycle so one task covers idle and conversion.
  task automatic put(input logic [4:0] c, input logic [11:0] d, input logic [1:0] s,
                     input logic [11:0] clr);
    @(posedge i_clk);
    for (int u = 0; u < NUM_UNITS; u++) begin
      cv[u] <= (c != 5'h1F);
      ch[u] <= c;
      dt[u] <= d;
      ts[u] <= s;
      cl[u] <= clr;
    end
  endtask : put

  // Waits until the conversion just driven has been taken, then records unit 0's result.
  task automatic grab();
    @(negedge i_clk);
    @(negedge i_clk);
    res_q.push_back(int'(o_la[0]));
  endtask : grab

  task automatic rnd_cycle(input logic link);
    logic [NUM_CH-1:0] e0;
    @(posedge i_clk);
    e0 = 12'($urandom);
    for (int u = 0; u < NUM_UNITS; u++) begin
      md[u] <= (u == 1) ? {link, 15'($urandom)} : 16'($urandom);
      {ct[u], iv[u], im[u], tg[u], st[u], cv[u]} <= 28'($urandom);
      en[u] <= (u == 1 && link) ? {e0[10:0], e0[11]} : e0;
      {lm[u], up[u]} <= 24'($urandom);
      {lo[u], dt[u]} <= 24'($urandom);
      ch[u] <= 5'($urandom_range(17));
      ts[u] <= 2'($urandom);
      cl[u] <= ($urandom_range(9) < 2) ? 12'($urandom) : 12'h000;
    end
  endtask : rnd_cycle

  initial begin
    for (int u = 0; u < NUM_UNITS; u++) begin
      {md[u], ct[u], iv[u], im[u], tg[u], st[u], cv[u], en[u], lm[u]} = '0;
      {up[u], lo[u], dt[u], ts[u], ch[u], cl[u]} = '0;
    end
    i_resetn = 1'b0;
    void'($urandom(9));
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    // One external input alternates with each of the three test sources.
    put(5'h07, 12'h5A3, 2'h0, 12'h000);
    grab();
    for (int k = 1; k < 4; k++) begin
      put(CHECK_CHAN, 12'(12'h3C0 * k), 2'(k), 12'h000);
      grab();
      put(5'h07, 12'h5A3, 2'(k), 12'h000);
      grab();
    end
    put(5'h1F, 12'h000, 2'h0, 12'h000);
    // Software verdict: external results agree, test results differ from all others.
    st_ok = 1'b1;
    for (int i = 0; i < 7; i++) begin
      for (int j = 0; j < 7; j++) begin
        if (i != j && ((i % 2 == 0) && (j % 2 == 0)) != (res_q[i] == res_q[j])) begin
          st_ok = 1'b0;
        end
      end
    end
    chk("self_test_verdict", 16'h0001, 16'(st_ok));
    $display("test self_test done");
    repeat (300) rnd_cycle(1'b0);
    $display("test unlinked done");
    repeat (300) rnd_cycle(1'b1);
    $display("test linked done");
    @(posedge i_clk);
    i_resetn <= 1'b0;
    // Inputs go quiet with reset, so no request stands at the edge that releases it.
    for (int u = 0; u < NUM_UNITS; u++) begin
      {md[u], ct[u], iv[u], im[u], tg[u], st[u], cv[u], en[u], cl[u], ts[u]} <= '0;
      lm[u] <= 12'hFFF;
      lo[u] <= 12'h100;
      up[u] <= 12'h200;
    end
    @(posedge i_clk);
    i_resetn <= 1'b1;
    put(5'h02, 12'h0FF, 2'h0, 12'h000);
    put(5'h03, 12'h100, 2'h0, 12'h000);
    put(5'h04, 12'h200, 2'h0, 12'h000);
    put(5'h05, 12'h201, 2'h0, 12'h000);
    put(5'h04, 12'h180, 2'h0, 12'h018);
    put(5'h1F, 12'h000, 2'h0, 12'h000);
    put(5'h1F, 12'h000, 2'h0, 12'h000);
    $display("test limits done");
    test_done();
  end
endmodule : dual_adc_sync_and_self_test_tb_top
`default_nettype wire
